// >>> design/sad_pkg.sv
/*
  constants, field layouts, target codes and helper functions of the system address decoder.
  assumes a 32-bit byte address from every bus master and one clock for all logic.
*/
package sad_pkg;

  // target codes, index into the one-hot select vector
  localparam int SAD_N_TGT = 15;
  localparam logic [3:0] TGT_DEFAULT = 4'h0;
  localparam logic [3:0] TGT_TRACE = 4'h1;
  localparam logic [3:0] TGT_ROMTAB = 4'h2;
  localparam logic [3:0] TGT_SCIO = 4'h3;
  localparam logic [3:0] TGT_SRAM = 4'h4;
  localparam logic [3:0] TGT_QUAD_A = 4'h5;
  localparam logic [3:0] TGT_RADIO = 4'h9;
  localparam logic [3:0] TGT_TMR_FIRST = 4'ha;
  localparam logic [3:0] TGT_TMR_SECOND = 4'hb;
  localparam logic [3:0] TGT_APB_OTHER = 4'hc;
  localparam logic [3:0] TGT_AHB_OTHER = 4'hd;
  localparam logic [3:0] TGT_RSVD_ZERO = 4'he;

  // system and debug region bounds
  localparam logic [31:0] TRACE_LO = 32'hf000_2000;
  localparam logic [31:0] TRACE_HI = 32'hf000_2fff;
  localparam logic [31:0] ROMTAB_LO = 32'hf000_0000;
  localparam logic [31:0] ROMTAB_HI = 32'hf000_0fff;
  localparam logic [31:0] SCIO_LO = 32'h5c00_0000;
  localparam logic [31:0] SCIO_HI = 32'h5c00_0403;
  localparam logic [31:0] SCIO_SPAN_LO = 32'h5800_0000;
  localparam logic [31:0] SCIO_SPAN_HI = 32'h5fff_ffff;
  localparam logic [31:0] SRAM_LO = 32'h2000_0000;
  localparam logic [31:0] SRAM_HI = 32'h2000_ffff;

  // peripheral window and named slots
  localparam logic [31:0] PERI_LO = 32'h4000_0000;
  localparam logic [31:0] PERI_HI = 32'h4fff_ffff;
  localparam logic [31:0] APB_HI = 32'h4014_ffff;
  localparam logic [31:0] AHB_LO = 32'h4015_0000;
  localparam logic [31:0] RADIO_LO = 32'h4014_0800;
  localparam logic [31:0] RADIO_HI = 32'h4014_0817;
  localparam logic [31:0] RADIO_GAP_LO = 32'h4014_0818;
  localparam logic [31:0] TMR1_LO = 32'h4004_1800;
  localparam logic [31:0] TMR1_HI = 32'h4004_18af;
  localparam logic [31:0] TMR1_GAP_LO = 32'h4004_18b0;
  localparam logic [31:0] TMR2_LO = 32'h4004_1c00;
  localparam logic [31:0] TMR2_HI = 32'h4004_1caf;
  localparam logic [31:0] TMR2_GAP_LO = 32'h4004_1cb0;
  localparam logic [31:0] TMR2_GAP_HI = 32'h4004_1fff;
  localparam logic [31:0] DMAC_LO = 32'h4015_0000;
  localparam logic [31:0] DMAC_HI = 32'h4015_03ff;
  localparam logic [31:0] FDMA_LO = 32'h4016_0000;
  localparam logic [31:0] FDMA_HI = 32'h4016_001f;
  localparam logic [31:0] CRYPT_LO = 32'h4017_0000;
  localparam logic [31:0] CRYPT_HI = 32'h4017_009b;

  // flash windows; a pair spans 256 KB, a quadrant 128 KB
  localparam logic [31:0] PAIR0_LO = 32'h1000_0000;
  localparam logic [31:0] PAIR1_LO = 32'h1400_0000;
  localparam logic [31:0] MIRROR0_LO = 32'h1800_0000;
  localparam logic [31:0] MIRROR1_LO = 32'h1c00_0000;
  localparam logic [31:0] PAIR_SPAN_HI = 32'h0003_ffff;
  localparam logic [31:0] REMAP_HI = 32'h0007_ffff;
  localparam logic [18:0] SEC_SEG_LO = 19'h7_e800;
  localparam logic [18:0] SEC_SEG_HI = 19'h7_e9ff;
  localparam logic [18:0] BOOT_A_LIN = 19'h3_e800;
  localparam logic [18:0] BOOT_B_LIN = 19'h7_ea00;
  localparam logic [18:0] BOOT_A_LEN = 19'h0_1800;
  localparam logic [18:0] BOOT_WIN_LEN = 19'h0_2e00;

  // register map and remap control fields
  localparam logic [3:0] REG_REMAP_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int F_REMAP_LSB = 0;
  localparam int F_REMAP_EN = 4;
  localparam int F_TWO_BANK = 8;
  localparam int F_BANK_SEL = 9;
  localparam int F_CASCADE = 12;
  localparam logic [3:0] REMAP_RESET = 4'h0;
  localparam logic REMAP_EN_RESET = 1'b0;
  localparam logic TWO_BANK_RESET = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int STRAP_SETTLE = 2;

  // strap capture waits for the pin synchroniser to fill
  typedef enum logic [1:0] {
    STRAP_WAIT0 = 2'b00,
    STRAP_WAIT1 = 2'b01,
    STRAP_WAIT2 = 2'b10,
    STRAP_HELD = 2'b11
  } sad_strap_t;

  // front decode result before flash quadrant resolution
  typedef struct packed {
    logic [3:0] tgt;
    logic [31:0] off;
    logic is_flash;
    logic [18:0] lin;
    logic boot_view;
  } sad_dec_t;

  function automatic logic sad_in(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] hi);
    sad_in = (a >= lo) && (a <= hi);
  endfunction : sad_in

endpackage : sad_pkg

// >>> design/sad_flash_map.sv
/*
  flash quadrant resolver: turns a linear 512 KB flash offset, or a boot-view offset,
  into a quadrant number and an offset inside it. purely combinational.
  assumes the caller already decided the access belongs to flash.
*/
`timescale 1ns/1ps
module sad_flash_map
  import sad_pkg::*;
(
  // request
  input wire logic [18:0] lin,
  input wire logic boot_view,
  // result
  output logic [1:0] quad,
  output logic [16:0] quad_off,
  output logic sec_seg,
  output logic boot_seg
);

  logic [18:0] eff;

  // boot view packs the two boot segments back to back from zero
  always_comb begin
    eff = lin;
    boot_seg = 1'b0;
    if (boot_view && (lin < BOOT_A_LEN)) begin
      eff = BOOT_A_LIN + lin;
      boot_seg = 1'b1;
    end else if (boot_view && (lin < BOOT_WIN_LEN)) begin
      eff = BOOT_B_LIN + (lin - BOOT_A_LEN);
      boot_seg = 1'b1;
    end
  end

  // bit 18 picks the pair, bit 17 the quadrant inside it
  assign quad = eff[18:17];
  assign quad_off = eff[16:0];
  assign sec_seg = (eff >= SEC_SEG_LO) && (eff <= SEC_SEG_HI);

endmodule : sad_flash_map

// >>> design/sad_decoder.sv
/*
  system address decoder top: registered target select for bus master requests,
  remap and bank control registers behind an axi4-lite slave, boot strap capture.
  assumes requests arrive on core_clk; boot_mode_pin is asynchronous, security_enable
  comes from flash controller logic on the same clock.
*/
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module sad_decoder
  import sad_pkg::*;
#(
  parameter int AXI_ADDR_W = 32
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // straps and status from outside
  input wire logic boot_mode_pin,
  input wire logic security_enable,
  // address request from a bus master
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic req_fetch,
  // decode result, one cycle later
  output logic rsp_valid,
  output logic [SAD_N_TGT-1:0] rsp_sel,
  output logic [31:0] rsp_off,
  output logic rsp_error,
  output logic rsp_zero,
  output logic rsp_sec_seg,
  output logic rsp_boot_seg,
  // timer cascade control
  output logic cascade_join,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  if (AXI_ADDR_W < 4) begin : g_bad_width
    $error("sad_decoder: AXI_ADDR_W must be at least 4");
  end

  typedef struct packed {
    // pin synchroniser and strap
    logic sync1;
    logic sync2;
    sad_strap_t strap;
    logic boot_latched;
    // remap control register
    logic [3:0] remap;
    logic remap_en;
    logic two_bank;
    logic bank_sel;
    logic cascade;
    // axi write side
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    // axi read side
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // decode result
    logic rsp_valid;
    logic [SAD_N_TGT-1:0] rsp_sel;
    logic [31:0] rsp_off;
    logic rsp_error;
    logic rsp_zero;
    logic rsp_sec_seg;
    logic rsp_boot_seg;
  } sad_state_t;

  sad_state_t st;
  sad_state_t next_st;
  sad_dec_t dec;
  logic [1:0] fl_quad;
  logic [16:0] fl_off;
  logic fl_sec;
  logic fl_boot;

  // reset image; only the control fields carry non-trivial meaning
  function automatic sad_state_t sad_reset_state();
    sad_state_t s;
    s = '0;
    s.strap = STRAP_WAIT0;
    s.remap = REMAP_RESET;
    s.remap_en = REMAP_EN_RESET;
    s.two_bank = TWO_BANK_RESET;
    s.bresp = RESP_OKAY;
    s.rresp = RESP_OKAY;
    return s;
  endfunction : sad_reset_state

  // plain target with offset from region base
  function automatic sad_dec_t sad_hit(input logic [3:0] t, input logic [31:0] a,
                                       input logic [31:0] lo);
    sad_dec_t d;
    d = '0;
    d.tgt = t;
    d.off = a - lo;
    return d;
  endfunction : sad_hit

  // flash access by linear offset
  function automatic sad_dec_t sad_flash(input logic [18:0] lin, input logic bv);
    sad_dec_t d;
    d = '0;
    d.tgt = TGT_QUAD_A;
    d.is_flash = 1'b1;
    d.lin = lin;
    d.boot_view = bv;
    return d;
  endfunction : sad_flash

  // peripheral window: named slots, reserved gaps, bridge for the rest of the APB range, error elsewhere
  function automatic sad_dec_t sad_peri(input logic [31:0] a);
    sad_dec_t d;
    d = sad_hit(TGT_DEFAULT, a, PERI_LO);
    if (sad_in(a, RADIO_LO, RADIO_HI)) begin
      d = sad_hit(TGT_RADIO, a, RADIO_LO);
    end else if (sad_in(a, RADIO_GAP_LO, APB_HI)) begin
      d = sad_hit(TGT_RSVD_ZERO, a, RADIO_GAP_LO);
    end else if (sad_in(a, TMR1_LO, TMR1_HI)) begin
      d = sad_hit(TGT_TMR_FIRST, a, TMR1_LO);
    end else if (sad_in(a, TMR1_GAP_LO, TMR2_LO - 32'h0000_0001)) begin
      d = sad_hit(TGT_RSVD_ZERO, a, TMR1_GAP_LO);
    end else if (sad_in(a, TMR2_LO, TMR2_HI)) begin
      d = sad_hit(TGT_TMR_SECOND, a, TMR2_LO);
    end else if (sad_in(a, TMR2_GAP_LO, TMR2_GAP_HI)) begin
      d = sad_hit(TGT_RSVD_ZERO, a, TMR2_GAP_LO);
    end else if (sad_in(a, PERI_LO, APB_HI)) begin
      d = sad_hit(TGT_APB_OTHER, a, PERI_LO);
    end else if (sad_in(a, DMAC_LO, DMAC_HI) || sad_in(a, FDMA_LO, FDMA_HI) ||
                 sad_in(a, CRYPT_LO, CRYPT_HI)) begin
      d = sad_hit(TGT_AHB_OTHER, a, AHB_LO);
    end
    return d;
  endfunction : sad_peri

  // remap window at zero; unlisted remap codes are reserved and refused
  function automatic sad_dec_t sad_remap(input logic [31:0] a, input sad_state_t s);
    sad_dec_t d;
    d = sad_hit(TGT_DEFAULT, a, 32'h0000_0000);
    if (!s.remap_en) begin
      d = sad_flash(a[18:0], s.boot_latched);
    end else if (s.remap == 4'h0) begin
      d = sad_flash(a[18:0], 1'b0);
    end else if (s.remap[0]) begin
      if (a <= (SRAM_HI - SRAM_LO)) begin
        d = sad_hit(TGT_SRAM, a, 32'h0000_0000);
      end
    end else if (s.remap[2:0] == 3'b100) begin
      d = sad_flash(a[18:0], 1'b1);
    end
    return d;
  endfunction : sad_remap

  // whole front decode; first match wins so only one target is named
  function automatic sad_dec_t sad_front(input logic [31:0] a, input logic wr,
                                         input logic fetch, input sad_state_t s,
                                         input logic secure);
    sad_dec_t d;
    d = sad_hit(TGT_DEFAULT, a, 32'h0000_0000);
    if (sad_in(a, TRACE_LO, TRACE_HI)) begin
      d = sad_hit(secure ? TGT_DEFAULT : TGT_TRACE, a, TRACE_LO);
    end else if (sad_in(a, ROMTAB_LO, ROMTAB_HI)) begin
      d = sad_hit(secure ? TGT_DEFAULT : TGT_ROMTAB, a, ROMTAB_LO);
    end else if (sad_in(a, SCIO_LO, SCIO_HI)) begin
      d = sad_hit(TGT_SCIO, a, SCIO_LO);
    end else if (sad_in(a, SCIO_SPAN_LO, SCIO_SPAN_HI)) begin
      d = sad_hit(TGT_RSVD_ZERO, a, SCIO_SPAN_LO);
    end else if (sad_in(a, PERI_LO, PERI_HI)) begin
      d = sad_peri(a);
    end else if (sad_in(a, SRAM_LO, SRAM_HI)) begin
      d = sad_hit(TGT_SRAM, a, SRAM_LO);
    end else if (a <= REMAP_HI) begin
      d = sad_remap(a, s);
    end else if (sad_in(a, PAIR0_LO, PAIR0_LO + PAIR_SPAN_HI)) begin
      // two-bank: both controllers overlap here, software picks which one
      d = sad_flash({s.two_bank & s.bank_sel, a[17:0]}, 1'b0);
    end else if (sad_in(a, PAIR1_LO, PAIR1_LO + PAIR_SPAN_HI)) begin
      if (!s.two_bank) begin
        d = sad_flash({1'b1, a[17:0]}, 1'b0);
      end
    end else if (sad_in(a, MIRROR0_LO, MIRROR0_LO + PAIR_SPAN_HI)) begin
      if (!wr && !fetch) begin
        d = sad_flash({1'b0, a[17:0]}, 1'b0);
      end
    end else if (sad_in(a, MIRROR1_LO, MIRROR1_LO + PAIR_SPAN_HI)) begin
      if (!wr && !fetch) begin
        d = sad_flash({1'b1, a[17:0]}, 1'b0);
      end
    end
    return d;
  endfunction : sad_front

  assign dec = sad_front(req_addr, req_write, req_fetch, st, security_enable);

  sad_flash_map u_flash_map (
    .lin(dec.lin),
    .boot_view(dec.boot_view),
    .quad(fl_quad),
    .quad_off(fl_off),
    .sec_seg(fl_sec),
    .boot_seg(fl_boot)
  );

  // bus handshakes; held low in reset and while frozen so nothing slips through
  assign s_axi_awready = ce & rst_n & ~st.aw_held & ~st.bvalid;
  assign s_axi_wready = ce & rst_n & ~st.w_held & ~st.bvalid;
  assign s_axi_arready = ce & rst_n & ~st.rvalid;

  // next-state logic for every piece of state
  always_comb begin
    logic aw_ok;
    logic w_ok;
    logic [3:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [3:0] raddr;
    logic [3:0] t;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    waddr = 4'h0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    raddr = 4'h0;
    t = 4'h0;
    next_st = st;

    // pin passes two flops; strap latched once the second holds a real sample
    next_st.sync1 = boot_mode_pin;
    next_st.sync2 = st.sync1;
    case (st.strap)
      STRAP_WAIT0: next_st.strap = STRAP_WAIT1;
      STRAP_WAIT1: next_st.strap = STRAP_WAIT2;
      STRAP_WAIT2: begin
        next_st.strap = STRAP_HELD;
        next_st.boot_latched = st.sync2;
      end
      STRAP_HELD: next_st.strap = STRAP_HELD;
      default: next_st.strap = STRAP_WAIT0;
    endcase

    // write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    aw_ok = st.aw_held | (s_axi_awvalid & s_axi_awready);
    w_ok = st.w_held | (s_axi_wvalid & s_axi_wready);
    waddr = st.aw_held ? st.aw_addr : s_axi_awaddr[3:0];
    wdata = st.w_held ? st.w_data : s_axi_wdata;
    wstrb = st.w_held ? st.w_strb : s_axi_wstrb;

    // register write once both halves are in
    if (aw_ok && w_ok) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (waddr == REG_REMAP_CTRL) begin
        if (wstrb[0]) begin
          next_st.remap = wdata[F_REMAP_LSB +: 4];
          next_st.remap_en = wdata[F_REMAP_EN];
        end
        if (wstrb[1]) begin
          next_st.two_bank = wdata[F_TWO_BANK];
          next_st.bank_sel = wdata[F_BANK_SEL];
          next_st.cascade = wdata[F_CASCADE];
        end
      end else if (waddr != REG_STATUS) begin
        next_st.bresp = RESP_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // register read
    raddr = s_axi_araddr[3:0];
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      if (raddr == REG_REMAP_CTRL) begin
        next_st.rdata[F_REMAP_LSB +: 4] = st.remap;
        next_st.rdata[F_REMAP_EN] = st.remap_en;
        next_st.rdata[F_TWO_BANK] = st.two_bank;
        next_st.rdata[F_BANK_SEL] = st.bank_sel;
        next_st.rdata[F_CASCADE] = st.cascade;
      end else if (raddr == REG_STATUS) begin
        next_st.rdata[0] = st.boot_latched;
        next_st.rdata[1] = security_enable;
        next_st.rdata[2] = (st.strap == STRAP_HELD);
      end else begin
        next_st.rresp = RESP_SLVERR;
      end
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // decode result; exactly one select bit per accepted request
    t = dec.is_flash ? (TGT_QUAD_A + {2'b00, fl_quad}) : dec.tgt;
    next_st.rsp_valid = req_valid;
    next_st.rsp_sel = '0;
    next_st.rsp_off = 32'h0000_0000;
    next_st.rsp_error = 1'b0;
    next_st.rsp_zero = 1'b0;
    next_st.rsp_sec_seg = 1'b0;
    next_st.rsp_boot_seg = 1'b0;
    if (req_valid) begin
      next_st.rsp_sel[t] = 1'b1;
      next_st.rsp_off = dec.is_flash ? {15'h0000, fl_off} : dec.off;
      next_st.rsp_error = (t == TGT_DEFAULT);
      next_st.rsp_zero = (t == TGT_RSVD_ZERO);
      next_st.rsp_sec_seg = dec.is_flash & fl_sec;
      next_st.rsp_boot_seg = dec.is_flash & fl_boot;
    end
  end

  // state register; reset returns to one-bank mode every time
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= sad_reset_state();
    end else if (ce) begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign rsp_valid = st.rsp_valid;
  assign rsp_sel = st.rsp_sel;
  assign rsp_off = st.rsp_off;
  assign rsp_error = st.rsp_error;
  assign rsp_zero = st.rsp_zero;
  assign rsp_sec_seg = st.rsp_sec_seg;
  assign rsp_boot_seg = st.rsp_boot_seg;
  assign cascade_join = st.cascade;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

endmodule : sad_decoder

// >>> bench/sad_master_model.sv
/*
  bus master model: issues one decode request at a time to the decoder.
  assumes the caller waits for each request to finish before the next.
*/
`timescale 1ns/1ps
module sad_master_model (
  // clock
  input wire logic core_clk,
  // request to the decoder
  output logic req_valid,
  output logic [31:0] req_addr,
  output logic req_write,
  output logic req_fetch
);
  // idle lines start low
  initial begin
    req_valid = 1'b0;
    req_addr = 32'h0;
    req_write = 1'b0;
    req_fetch = 1'b0;
  end

  // one request for one edge; qualifiers then flip so stale values never look valid
  task automatic issue(input logic [31:0] a, input logic w, input logic f);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_addr <= a;
    req_write <= w;
    req_fetch <= f;
    @(posedge core_clk);
    req_valid <= 1'b0;
    req_addr <= ~a;
    req_write <= ~w;
    req_fetch <= ~f;
  endtask : issue
endmodule : sad_master_model

// >>> bench/sad_decoder_asserts.sv
/*
  checker for the decode result of the address decoder.
  assumes one clock; bound to every sad_decoder instance.
*/
`timescale 1ns/1ps
module sad_decoder_asserts
  import sad_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // request side
  input wire logic ce,
  input wire logic security_enable,
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic req_fetch,
  // decode result
  input wire logic rsp_valid,
  input wire logic [SAD_N_TGT-1:0] rsp_sel,
  input wire logic rsp_error,
  input wire logic rsp_zero
);
  // a request taken this cycle
  wire logic go = ce && req_valid;
  wire logic [31:0] a = req_addr;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_rsp_follows: assert property (go |=> rsp_valid) else $error("no decode result");
  a_one_target: assert property (rsp_valid |-> $onehot(rsp_sel)) else $error("select not one-hot");
  a_sel_quiet: assert property (ce && !req_valid |=> rsp_sel == '0) else $error("stray select");
  a_error_default: assert property (rsp_valid |-> rsp_error == rsp_sel[0])
    else $error("error flag disagrees with select");
  a_secure_trace: assert property (go && security_enable && a[31:12] == 20'hf0002 |=> rsp_sel[0])
    else $error("trace buffer open while secured");
  a_port_window: assert property (go && a >= 32'h5c00_0000 && a <= 32'h5c00_0403 |=> rsp_sel[3])
    else $error("single-cycle port missed");
  a_mirror_readonly: assert property (go && (req_write || req_fetch) &&
    (a[31:18] == 14'h0600 || a[31:18] == 14'h0700) |=> rsp_error) else $error("mirror not refused");
  a_low_rsvd_zero: assert property (go && a >= 32'h4014_0818 && a <= 32'h4014_ffff |=>
    rsp_zero && !rsp_error) else $error("low reserved not zero sink");
  a_high_rsvd_err: assert property (go && a >= 32'h4017_009c && a <= 32'h4fff_ffff |=> rsp_error)
    else $error("high reserved no error");
  a_radio_slot: assert property (go && a >= 32'h4014_0800 && a <= 32'h4014_0817 |=> rsp_sel[9])
    else $error("radio slot missed");
endmodule : sad_decoder_asserts

bind sad_decoder sad_decoder_asserts u_sad_decoder_asserts (.core_clk, .rst_n, .ce,
  .security_enable, .req_valid, .req_addr, .req_write, .req_fetch, .rsp_valid, .rsp_sel,
  .rsp_error, .rsp_zero);

// >>> bench/testbench.sv
/*
  self-checking bench for the address decoder: decode table, remap and bank control.
  assumes the master model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module testbench;
  import sad_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic boot_mode_pin = 1'b0;
  logic security_enable = 1'b0;
  logic req_valid, req_write, req_fetch, rsp_valid, rsp_error, rsp_zero;
  logic rsp_sec_seg, rsp_boot_seg, cascade_join;
  logic [31:0] req_addr, rsp_off, s_axi_rdata;
  logic [SAD_N_TGT-1:0] rsp_sel;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] d;
  int bad_count = 0;
  int check_count = 0;

  sad_master_model u_sad_master_model (.core_clk, .req_valid, .req_addr, .req_write, .req_fetch);
  sad_decoder u_sad_decoder (.core_clk, .rst_n, .ce(1'b1), .boot_mode_pin, .security_enable,
    .req_valid, .req_addr, .req_write, .req_fetch, .rsp_valid, .rsp_sel, .rsp_off, .rsp_error,
    .rsp_zero, .rsp_sec_seg, .rsp_boot_seg, .cascade_join, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  // 125 MHz clock
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // hang guard, far beyond the hundred or so cycles the run needs
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end

  task automatic do_reset;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  // aw and w offered together, each dropped once taken; only the watchdog ends the wait
  task automatic axw(input logic [31:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  // one decode, then compare target and error flag after the result edge settles
  task automatic dx(input logic [31:0] a, input logic w, input logic f, input int i);
    u_sad_master_model.issue(a, w, f);
    #1;
    check("rsp_valid", {31'h0, rsp_valid}, 32'h1);
    check("rsp_sel", 32'(rsp_sel), 32'h1 << i);
    check("rsp_error", {31'h0, rsp_error}, {31'h0, i == 0});
    check("rsp_zero", {31'h0, rsp_zero}, {31'h0, i == 14});
  endtask : dx

  task automatic t_map;
    dx(32'h1000_0010, 1'b0, 1'b1, 5);
    check("rsp_off", rsp_off, 32'h10);
    dx(32'h1002_0004, 1'b1, 1'b0, 6);
    dx(32'h1403_e800, 1'b0, 1'b0, 8);
    check("sec_seg", {31'h0, rsp_sec_seg}, 32'h1);
    dx(32'h1c00_0010, 1'b0, 1'b0, 7);
    dx(32'h1800_0000, 1'b1, 1'b0, 0);
    dx(32'h1c00_0000, 1'b0, 1'b1, 0);
    dx(32'h5c00_0403, 1'b0, 1'b0, 3);
    dx(32'h5c00_0404, 1'b0, 1'b0, 14);
    dx(32'h4014_0817, 1'b0, 1'b0, 9);
    dx(32'h4004_0800, 1'b0, 1'b0, 12);
    dx(32'h4014_0818, 1'b1, 1'b0, 14);
    dx(32'h4004_1800, 1'b0, 1'b0, 10);
    dx(32'h4004_1c00, 1'b0, 1'b0, 11);
    dx(32'h4015_0000, 1'b0, 1'b0, 13);
    dx(32'h4017_009c, 1'b0, 1'b0, 0);
    dx(32'h3000_0000, 1'b0, 1'b0, 0);
    dx(32'hf000_2000, 1'b0, 1'b0, 1);
    @(posedge core_clk) security_enable <= 1'b1;
    dx(32'hf000_2000, 1'b0, 1'b0, 0);
    dx(32'hf000_0000, 1'b0, 1'b0, 0);
    @(posedge core_clk) security_enable <= 1'b0;
    dx(32'hf000_0000, 1'b0, 1'b0, 2);
  endtask : t_map

  task automatic t_remap;
    dx(32'h0000_0010, 1'b0, 1'b1, 5);
    axw(32'h0, 32'h11, r);
    dx(32'h0000_0010, 1'b0, 1'b1, 4);
    axw(32'h0, 32'h1300, r);
    axr(32'h0, d, r);
    check("remap_ctrl", d, 32'h1300);
    check("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
    check("cascade_join", {31'h0, cascade_join}, 32'h1);
    dx(32'h1000_0000, 1'b1, 1'b0, 7);
    dx(32'h1800_0004, 1'b0, 1'b0, 5);
    check("rsp_off", rsp_off, 32'h4);
    dx(32'h1c00_0000, 1'b0, 1'b0, 7);
    axw(32'h8, 32'h0, r);
    check("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    axr(32'h8, d, r);
    check("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    check("rdata", d, 32'h0);
  endtask : t_remap

  // boot pin high across a fresh power-on; bank mode must be back to one bank
  task automatic t_boot;
    boot_mode_pin <= 1'b1;
    do_reset();
    repeat (5) @(posedge core_clk);
    axr(32'h0, d, r);
    check("remap_ctrl", d, 32'h0);
    axr(32'h4, d, r);
    check("status", d, 32'h5);
    dx(32'h0000_0000, 1'b0, 1'b1, 6);
    check("rsp_off", rsp_off, 32'h1e800);
    check("boot_seg", {31'h0, rsp_boot_seg}, 32'h1);
    dx(32'h0000_1800, 1'b0, 1'b1, 8);
    check("rsp_off", rsp_off, 32'h1ea00);
  endtask : t_boot

  initial begin
    do_reset();
    t_map();
    t_remap();
    t_boot();
    end_of_test();
  end
endmodule : testbench
